// >>> rtl/dpcs_pkg.sv
// Package: offsets, field positions and codes of the debug port control/status block
package dpcs_pkg;
  // Register offsets (byte addresses, low two bits always zero)
  localparam logic [3:0] DPCS_OFS_KILL    = 4'h0;
  localparam logic [3:0] DPCS_OFS_CTRL    = 4'h4;
  localparam logic [3:0] DPCS_BANK_CTRL   = 4'h0;
  // Control/status field positions
  localparam int DPCS_SYS_ACK_BIT  = 31;
  localparam int DPCS_SYS_REQ_BIT  = 30;
  localparam int DPCS_DBG_ACK_BIT  = 29;
  localparam int DPCS_DBG_REQ_BIT  = 28;
  localparam int DPCS_RST_ACK_BIT  = 27;
  localparam int DPCS_RST_REQ_BIT  = 26;
  localparam int DPCS_CNT_LSB      = 12;
  localparam int DPCS_MASK_LSB     = 8;
  localparam int DPCS_WDERR_BIT    = 7;
  localparam int DPCS_MODE_LSB     = 2;
  // Transaction-kill field positions
  localparam int DPCS_WDERR_CLR_BIT = 3;
  // Reset values
  localparam logic        DPCS_REQ_RST   = 1'h0;
  localparam logic        DPCS_WDERR_RST = 1'h0;
  localparam logic [11:0] DPCS_CNT_RST   = 12'h000;
  localparam logic [3:0]  DPCS_MASK_RST  = 4'hF;
  localparam logic [1:0]  DPCS_MODE_RST  = 2'h0;
  // Transfer modes
  typedef enum logic [1:0] {
    DPCS_MODE_NORMAL  = 2'h0,
    DPCS_MODE_VERIFY  = 2'h1,
    DPCS_MODE_COMPARE = 2'h2,
    DPCS_MODE_RSVD    = 2'h3
  } dpcs_mode_t;
endpackage : dpcs_pkg

// >>> rtl/dpcs_ctrl_status.sv
// Debug port control/status word, transaction-kill register and lane compare
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Two-wire: kill register at offset 0, any bank
// - Scan-chain: kill register via its own chain
// - Register address low two bits always zero
// - Control/status is 32-bit mixed-access register
// - Bit 31 shows system power ack, read-only
// - Bit 30 drives system power request, resets 0
// - Bit 29 shows debug power ack, read-only
// - Bit 28 drives debug power request, resets 0
// - Bit 27 shows debug reset ack, read-only
// - Bit 26 drives debug reset request, resets 0
// - Bits 23:12 optional transaction counter
// - Pushed ops compare written word bytewise with target
// - Mask bit n includes byte lane n
// - Zero mask bit excludes its byte
// - Mask used only in verify or compare mode
// - Parity or framing error sets write error flag
// - Discarded accepted write sets write error flag
// - Scan-chain: flag reads zero; two-wire: read-only
// - Flag clears only by kill-register clear bit
// - Write error flag zero after reset
// - Mode 00 normal, 01 verify, 10 compare
// - Write error clear is kill register bit 3
module dpcs_ctrl_status #(
  parameter bit SCAN_CHAIN   = 1'b0,
  parameter bit MINIMAL      = 1'b0,
  parameter bit RST_REQ_IMPL = 1'b1
) (
  // System clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Link clock domain register access
  input  wire logic        link_clock,
  input  wire logic        link_rst,
  input  wire logic        link_wr,
  input  wire logic        link_rd,
  input  wire logic        link_kill_chain,
  input  wire logic [3:0]  link_addr,
  input  wire logic [3:0]  port_bank_select,
  input  wire logic [31:0] link_wdata,
  output logic      [31:0] link_rdata,
  // Link error events (link clock)
  input  wire logic        link_data_error,
  // Write discard event (system clock)
  input  wire logic        write_discarded,
  // Power and reset handshakes
  input  wire logic        system_power_ack,
  input  wire logic        debug_power_ack,
  input  wire logic        debug_reset_ack,
  output logic             system_power_request,
  output logic             debug_power_request,
  output logic             debug_reset_request,
  // Pushed compare (system clock)
  input  wire logic        push_valid,
  input  wire logic [31:0] push_wdata,
  input  wire logic [31:0] push_tdata,
  output logic             push_match,
  output logic             push_done,
  output logic [1:0]       transfer_mode,
  output logic [3:0]       compare_lane_mask
);
  // Link-domain register state
  logic        sys_req_q, dbg_req_q, rst_req_q;
  logic [11:0] cnt_q;
  logic [3:0]  mask_q;
  logic [1:0]  mode_q;
  // Crossing and synchroniser state
  logic        cfg_req_q;
  logic        cfg_pend_q;
  logic [5:0]  cfg_snap_q;
  logic        cfg_ack_sync;
  logic        cfg_tgl_sync;
  logic        cfg_seen_q;
  logic [1:0]  cfg_mode_q;
  logic [3:0]  cfg_mask_q;
  logic        sys_ack_s;
  logic        dbg_ack_s;
  logic        rst_ack_s;
  logic        disc_tgl_sync;
  logic        disc_seen_q;
  logic        wderr_q;

  // Decode; low address bits must be zero
  wire aligned      = (link_addr[1:0] == 2'h0);
  wire map_access   = !link_kill_chain && aligned;
  wire at_kill_ofs  = link_addr == dpcs_pkg::DPCS_OFS_KILL;
  wire at_ctrl_ofs  = link_addr == dpcs_pkg::DPCS_OFS_CTRL;
  wire at_ctrl_bank = port_bank_select == dpcs_pkg::DPCS_BANK_CTRL;

  // Scan-chain build reaches the kill register only on its own chain
  wire kill_chain_wr = link_wr && link_kill_chain;
  // Two-wire build ignores the bank field at offset zero
  wire kill_map_wr   = link_wr && map_access && at_kill_ofs;
  wire kill_wr       = SCAN_CHAIN ? kill_chain_wr : kill_map_wr;

  wire ctrl_sel  = map_access && at_ctrl_ofs && at_ctrl_bank;
  wire ctrl_wr   = link_wr && ctrl_sel;
  wire wderr_clr = kill_wr && link_wdata[dpcs_pkg::DPCS_WDERR_CLR_BIT];

  // Acks are levels from other power domains, so each passes two flops
  // System power ack
  dpcs_sync2 #(
    .WIDTH (1)
  ) sys_ack_sync_i (
    .clock (link_clock),
    .rst   (link_rst),
    .d     (system_power_ack),
    .q     (sys_ack_s)
  );
  // Debug power ack
  dpcs_sync2 #(
    .WIDTH (1)
  ) dbg_ack_sync_i (
    .clock (link_clock),
    .rst   (link_rst),
    .d     (debug_power_ack),
    .q     (dbg_ack_s)
  );
  // Debug reset ack
  dpcs_sync2 #(
    .WIDTH (1)
  ) rst_ack_sync_i (
    .clock (link_clock),
    .rst   (link_rst),
    .d     (debug_reset_ack),
    .q     (rst_ack_s)
  );

  // Next values of the writable fields
  wire        sys_req_d = link_wdata[dpcs_pkg::DPCS_SYS_REQ_BIT];
  wire        dbg_req_d = link_wdata[dpcs_pkg::DPCS_DBG_REQ_BIT];
  // Read-as-zero build never lets the reset request out
  wire        rst_req_d = RST_REQ_IMPL & link_wdata[dpcs_pkg::DPCS_RST_REQ_BIT];
  // Minimal build keeps these at their reset values (mask all ones); nonzero writes are undefined anyway
  wire [11:0] cnt_d     = MINIMAL ? dpcs_pkg::DPCS_CNT_RST
                                  : link_wdata[dpcs_pkg::DPCS_CNT_LSB +: 12];
  wire [3:0]  mask_d    = MINIMAL ? dpcs_pkg::DPCS_MASK_RST
                                  : link_wdata[dpcs_pkg::DPCS_MASK_LSB +: 4];
  wire [1:0]  mode_d    = MINIMAL ? dpcs_pkg::DPCS_MODE_RST
                                  : link_wdata[dpcs_pkg::DPCS_MODE_LSB +: 2];

  // System power request
  always_ff @(posedge link_clock) begin
    if (link_rst) sys_req_q <= dpcs_pkg::DPCS_REQ_RST;
    else if (ctrl_wr) sys_req_q <= sys_req_d;
  end

  // Debug power request
  always_ff @(posedge link_clock) begin
    if (link_rst) dbg_req_q <= dpcs_pkg::DPCS_REQ_RST;
    else if (ctrl_wr) dbg_req_q <= dbg_req_d;
  end

  // Debug reset request
  always_ff @(posedge link_clock) begin
    if (link_rst) rst_req_q <= dpcs_pkg::DPCS_REQ_RST;
    else if (ctrl_wr) rst_req_q <= rst_req_d;
  end

  // Transaction counter; reset value chosen since power-up is undefined
  always_ff @(posedge link_clock) begin
    if (link_rst) cnt_q <= dpcs_pkg::DPCS_CNT_RST;
    else if (ctrl_wr) cnt_q <= cnt_d;
  end

  // Lane mask resets to all lanes so a first compare checks the whole word
  always_ff @(posedge link_clock) begin
    if (link_rst) mask_q <= dpcs_pkg::DPCS_MASK_RST;
    else if (ctrl_wr) mask_q <= mask_d;
  end

  // Transfer mode resets to normal
  always_ff @(posedge link_clock) begin
    if (link_rst) mode_q <= dpcs_pkg::DPCS_MODE_RST;
    else if (ctrl_wr) mode_q <= mode_d;
  end

  // Pending flag remembers a control write made while a crossing is in flight
  wire cfg_busy   = cfg_req_q ^ cfg_ack_sync;
  wire cfg_launch = cfg_pend_q && !cfg_busy;
  always_ff @(posedge link_clock) begin
    if (link_rst) cfg_pend_q <= 1'b0;
    else if (ctrl_wr) cfg_pend_q <= 1'b1;
    else if (cfg_launch) cfg_pend_q <= 1'b0;
  end

  // Snapshot stays still until the system side has taken it
  always_ff @(posedge link_clock) begin
    if (link_rst) begin
      cfg_req_q  <= 1'b0;
      cfg_snap_q <= {dpcs_pkg::DPCS_MODE_RST, dpcs_pkg::DPCS_MASK_RST};
    end else if (cfg_launch) begin
      cfg_req_q  <= ~cfg_req_q;
      cfg_snap_q <= {mode_q, mask_q};
    end
  end

  // System side answer returns for the busy check
  dpcs_sync2 #(
    .WIDTH (1)
  ) cfg_ack_sync_i (
    .clock (link_clock),
    .rst   (link_rst),
    .d     (cfg_seen_q),
    .q     (cfg_ack_sync)
  );

  // Discard event crosses from system clock as a toggle
  logic disc_tgl_q;
  always_ff @(posedge clock) begin
    if (sys_rst) disc_tgl_q <= 1'b0;
    else if (write_discarded) disc_tgl_q <= ~disc_tgl_q;
  end
  dpcs_sync2 #(
    .WIDTH (1)
  ) disc_sync_i (
    .clock (link_clock),
    .rst   (link_rst),
    .d     (disc_tgl_q),
    .q     (disc_tgl_sync)
  );
  always_ff @(posedge link_clock) begin
    if (link_rst) disc_seen_q <= 1'b0;
    else disc_seen_q <= disc_tgl_sync;
  end
  wire disc_evt = disc_tgl_sync ^ disc_seen_q;

  // Sticky flag: set wins over clear, so an error landing on the clear is kept
  wire wderr_set = link_data_error || disc_evt;
  always_ff @(posedge link_clock) begin
    if (link_rst) wderr_q <= dpcs_pkg::DPCS_WDERR_RST;
    else if (wderr_set) wderr_q <= 1'b1;
    else if (wderr_clr) wderr_q <= 1'b0;
  end
  // Scan-chain build reserves the flag as zero
  wire wderr_rd = SCAN_CHAIN ? 1'b0 : wderr_q;

  // Read data; acks shown read-only
  wire [5:0]  power_bits = {sys_ack_s, sys_req_q, dbg_ack_s, dbg_req_q,
                            rst_ack_s, rst_req_q};
  // Reserved bits read zero
  wire [1:0]  rsvd_hi    = 2'h0;
  wire [2:0]  rsvd_mid   = 3'h0;
  wire [1:0]  rsvd_lo    = 2'h0;
  wire [31:0] ctrl_word  = {power_bits, rsvd_hi, cnt_q, mask_q,
                            wderr_rd, rsvd_mid, mode_q, rsvd_lo};

  // Unmapped and misaligned reads answer zero
  wire [31:0] rdata_d = ctrl_sel ? ctrl_word : 32'h0000_0000;
  always_ff @(posedge link_clock) begin
    if (link_rst) link_rdata <= 32'h0000_0000;
    else if (link_rd) link_rdata <= rdata_d;
  end

  // Requests leave straight from their bits
  assign system_power_request = sys_req_q;
  assign debug_power_request  = dbg_req_q;
  assign debug_reset_request  = rst_req_q;

  // Mode and mask cross as a snapshot under a toggle handshake
  dpcs_sync2 #(
    .WIDTH (1)
  ) cfg_sync_i (
    .clock (clock),
    .rst   (sys_rst),
    .d     (cfg_req_q),
    .q     (cfg_tgl_sync)
  );
  wire cfg_evt = cfg_tgl_sync ^ cfg_seen_q;

  always_ff @(posedge clock) begin
    if (sys_rst) cfg_seen_q <= 1'b0;
    else cfg_seen_q <= cfg_tgl_sync;
  end

  // Capture only after the toggle settled, when the snapshot is stable
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg_mode_q <= dpcs_pkg::DPCS_MODE_RST;
      cfg_mask_q <= dpcs_pkg::DPCS_MASK_RST;
    end else if (cfg_evt) begin
      cfg_mode_q <= cfg_snap_q[5:4];
      cfg_mask_q <= cfg_snap_q[3:0];
    end
  end
  assign transfer_mode     = cfg_mode_q;
  assign compare_lane_mask = cfg_mask_q;

  // Bytewise compare with lane masking
  wire [3:0] lane_eq;

  genvar g;
  // One lane per byte of the word
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      dpcs_lane_cmp #(
        .LANE_BITS (8)
      ) lane_cmp_i (
        .enable (compare_lane_mask[g]),
        .wbyte  (push_wdata[8*g +: 8]),
        .tbyte  (push_tdata[8*g +: 8]),
        .equal  (lane_eq[g])
      );
    end
  endgenerate
  // Reserved mode behaves as normal: no compare is reported
  wire is_verify  = transfer_mode == dpcs_pkg::DPCS_MODE_VERIFY;
  wire is_compare = transfer_mode == dpcs_pkg::DPCS_MODE_COMPARE;
  wire pushed     = is_verify || is_compare;

  // Compare result of the whole word
  wire all_lanes_eq = &lane_eq;
  wire push_take    = push_valid && pushed;

  // Done marks each compare in a pushed mode
  always_ff @(posedge clock) begin
    if (sys_rst) push_done <= 1'b0;
    else push_done <= push_take;
  end

  // Match is only meaningful while done is high
  always_ff @(posedge clock) begin
    if (sys_rst) push_match <= 1'b0;
    else push_match <= push_take && all_lanes_eq;
  end
endmodule : dpcs_ctrl_status

// Two-flop synchroniser; only the second stage is read outside
module dpcs_sync2 #(
  parameter int WIDTH = 1
) (
  // Destination clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Asynchronous input and synchronised output
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  // First stage may go metastable, so nothing else reads it
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : dpcs_sync2

// One byte lane of the pushed compare; a masked-off lane always agrees
module dpcs_lane_cmp #(
  parameter int LANE_BITS = 8
) (
  // Lane select
  input  wire logic                 enable,
  // Written and target bytes
  input  wire logic [LANE_BITS-1:0] wbyte,
  input  wire logic [LANE_BITS-1:0] tbyte,
  // Result
  output logic                      equal
);
  wire bytes_same = (wbyte == tbyte);
  assign equal = !enable || bytes_same;
endmodule : dpcs_lane_cmp
`default_nettype wire

// >>> sim/dpcs_ack_model.sv
// Power and reset controller model: each ack trails its request
`timescale 1ns/1ps
`default_nettype none
module dpcs_ack_model (
  input  wire logic clock, system_power_request, debug_power_request, debug_reset_request,
  output logic      system_power_ack, debug_power_ack, debug_reset_ack
);
  logic [2:0] lag1_q, lag2_q;
  // Lag keeps acks visibly behind requests
  always_ff @(posedge clock) begin
    lag1_q <= {system_power_request, debug_power_request, debug_reset_request};
    lag2_q <= lag1_q;
  end
  assign {system_power_ack, debug_power_ack, debug_reset_ack} = lag2_q;
endmodule : dpcs_ack_model
`default_nettype wire

// >>> sim/dpcs_ctrl_status_properties.sv
// Port checks of the control/status block
`timescale 1ns/1ps
`default_nettype none
module dpcs_ctrl_status_properties (
  input wire logic        clock, sys_rst, link_clock, link_rst, link_wr, link_rd, link_kill_chain,
  input wire logic [3:0]  link_addr, port_bank_select,
  input wire logic [31:0] link_wdata, link_rdata,
  input wire logic        link_data_error, push_valid, push_done, push_match,
  input wire logic        system_power_request, debug_power_request, debug_reset_request,
  input wire logic [1:0]  transfer_mode
);
  wire lc = link_clock;
  wire rc = link_addr == 4'h4 && port_bank_select == 4'h0 && !link_kill_chain;
  wire wc = link_wr && rc;
  property p_sys; @(posedge lc) disable iff (link_rst) wc |=> system_power_request == $past(link_wdata[30]); endproperty
  property p_dbg; @(posedge lc) disable iff (link_rst) wc |=> debug_power_request == $past(link_wdata[28]); endproperty
  property p_rst; @(posedge lc) disable iff (link_rst) wc |=> debug_reset_request == $past(link_wdata[26]); endproperty
  property p_rel; @(posedge lc) disable iff (link_rst)
    $fell(link_rst) |-> !system_power_request && !debug_power_request && !debug_reset_request; endproperty
  property p_err; @(posedge lc) disable iff (link_rst) link_data_error ##2 (link_rd && rc) |=> link_rdata[7]; endproperty
  property p_algn; @(posedge lc) disable iff (link_rst) link_rd && link_addr[1:0] != 2'h0 |=> link_rdata == 32'h0; endproperty
  property p_kill; @(posedge lc) disable iff (link_rst) link_rd && link_addr == 4'h0 |=> link_rdata == 32'h0; endproperty
  wire pm = transfer_mode == 2'h1 || transfer_mode == 2'h2;
  property p_push; @(posedge clock) disable iff (sys_rst) push_valid && pm |=> push_done; endproperty
  property p_nopush; @(posedge clock) disable iff (sys_rst) !(push_valid && pm) |=> !push_done; endproperty
  a_sys: assert property (p_sys) else $error("sys request");
  a_dbg: assert property (p_dbg) else $error("dbg request");
  a_rst: assert property (p_rst) else $error("rst request");
  a_rel: assert property (p_rel) else $error("request reset");
  a_err: assert property (p_err) else $error("error flag");
  a_algn: assert property (p_algn) else $error("misaligned read");
  a_kill: assert property (p_kill) else $error("kill read");
  a_push: assert property (p_push) else $error("push done");
  a_nopush: assert property (p_nopush) else $error("stray push done");
  cover property (@(posedge lc) link_data_error);
  cover property (@(posedge lc) link_wr && link_addr == 4'h0);
  cover property (@(posedge clock) push_done && !push_match);
endmodule : dpcs_ctrl_status_properties
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the control/status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clock = 0, sys_rst = 1, link_clock = 0, link_rst = 1, link_wr = 0, link_rd = 0, link_kill_chain = 0;
  logic        link_data_error = 0, write_discarded = 0, push_valid = 0, push_match, push_done;
  logic        system_power_ack, debug_power_ack, debug_reset_ack;
  logic        system_power_request, debug_power_request, debug_reset_request;
  logic [3:0]  link_addr = 0, port_bank_select = 0, compare_lane_mask;
  logic [31:0] link_wdata = 0, link_rdata, push_wdata = 0, push_tdata = 0;
  logic [1:0]  transfer_mode;
  int          num_errors = 0, cmp_count = 0;
  dpcs_ctrl_status dpcs_ctrl_status_i (.*);
  dpcs_ack_model dpcs_ack_model_i (.*);
  always #2.5 clock = ~clock;
  // Offset start keeps link edges apart from system edges
  initial begin
    #1.3;
    forever #15 link_clock = ~link_clock;
  end
  task automatic chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, b, input logic [31:0] d);
    @(posedge link_clock) #1 {link_wr, link_addr, port_bank_select, link_wdata} = {1'b1, a, b, d};
    @(posedge link_clock) #1 link_wr = 0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge link_clock) #1 {link_rd, link_addr, port_bank_select} = {1'b1, a, 4'h0};
    @(posedge link_clock) #1 link_rd = 0;
    chk(link_rdata, e);
  endtask : rd
  task automatic push(input logic [31:0] w, t, input logic m);
    @(posedge clock) #1 {push_valid, push_wdata, push_tdata} = {1'b1, w, t};
    @(posedge clock) #1 push_valid = 0;
    chk(32'({push_done, push_match}), {31'h1, m});
  endtask : push
  task automatic finish_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (2) @(posedge link_clock);
    #1 {sys_rst, link_rst} = 2'h0;
    rd(4'h4, 32'h0000_0F00);
    wr(4'h4, 4'h0, 32'hFC00_0384);
    repeat (6) @(posedge link_clock);
    rd(4'h4, 32'hFC00_0304);
    chk(32'({system_power_request, debug_power_request, debug_reset_request}), 32'h7);
    chk(32'({transfer_mode, compare_lane_mask}), 32'h13);
    push(32'h1234_5678, 32'hFF34_5678, 1'b1);
    push(32'h1234_5678, 32'h1234_56FF, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(4'h4, 4'h0, 32'h0000_0008 | (32'h0000_0100 << i));
      repeat (3) @(posedge link_clock);
      push(32'h0, 32'h1 << (8 * i), 1'b0);
      push(32'h0, ~(32'hFF << (8 * i)), 1'b1);
    end
    @(posedge link_clock) #1 link_data_error = 1;
    @(posedge link_clock) #1 link_data_error = 0;
    rd(4'h4, 32'h0000_0888);
    wr(4'h4, 4'h0, 32'h0000_0000);
    rd(4'h4, 32'h0000_0080);
    wr(4'h0, 4'h5, 32'h0000_0008);
    rd(4'h4, 32'h0000_0000);
    @(posedge clock) #1 write_discarded = 1;
    @(posedge clock) #1 write_discarded = 0;
    repeat (6) @(posedge link_clock);
    rd(4'h4, 32'h0000_0080);
    wr(4'h0, 4'h0, 32'h0000_0008);
    wr(4'h4, 4'h0, 32'h0000_0000);
    rd(4'h5, 32'h0000_0000);
    rd(4'h0, 32'h0000_0000);
    finish_test();
  end
endmodule : testbench
bind dpcs_ctrl_status dpcs_ctrl_status_properties dpcs_ctrl_status_properties_i (.*);
`default_nettype wire
